// [src/fram_spi_defines.svh]
// Constants for the serial nonvolatile memory slave
`ifndef FRAM_SPI_DEFINES_SVH
`define FRAM_SPI_DEFINES_SVH

// ****************************************
// Command opcodes
// ****************************************
`define SET_WRITE_LATCH_CMD 8'h06
`define CLEAR_WRITE_LATCH_CMD 8'h04
`define STATUS_READ_CMD 8'h05
`define STATUS_WRITE_CMD 8'h01
`define ARRAY_READ_CMD 8'h03
`define ARRAY_WRITE_CMD 8'h02

// ****************************************
// Status byte field positions
// ****************************************
`define SR_LOCK_BIT 7
`define SR_BP_HI_BIT 3
`define SR_BP_LO_BIT 2
`define SR_LATCH_BIT 1

// ****************************************
// Reset values
// ****************************************
`define SR_LOCK_RST 1'b0
`define SR_BP_RST 2'h0
`define LATCH_RST 1'b0

// ****************************************
// Array addressing
// ****************************************
`define ADDR_W 11
`define ARRAY_TOP 11'h7FF
`define ADDR_ZERO 11'h000
`define LAST_BIT 3'h7
`define PROT_QTR_START 13'h1800
`define PROT_HALF_START 13'h1000

`endif

// [src/fram_spi_pkg.sv]
// Types shared by the serial nonvolatile memory slave
`default_nettype none
package fram_spi_pkg;

  // Gray coded along opcode, address, write data
  typedef enum logic [2:0] {
    ST_CMD   = 3'h0,
    ST_ADDR  = 3'h1,
    ST_WR    = 3'h3,
    ST_RD    = 3'h2,
    ST_SR_WR = 3'h6,
    ST_SR_RD = 3'h7,
    ST_DONE  = 3'h5
  } cmd_state_t;

endpackage
`default_nettype wire

// [src/fram_array.sv]
// Byte array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module fram_array #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [DATA_W-1:0] rdata_o
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rdata_reg;

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem[raddr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule
`default_nettype wire

// [src/serial_fram_access_protect.sv]
// Serial memory slave with write latch, block and status protection
//
// Summary of operation
// - Array writes guarded only by write latch and block-protect bits.
// - Lock bit clear: protect pin ignored for status writes.
// - Lock bit set and protect pin low: status writes rejected.
// - Array byte written only while the write latch is set.
// - Write address is two bytes; only the low 11 bits used.
// - Write bytes stored at consecutive addresses, no page limit.
// - Address past 7FFh wraps to 0000h on reads and writes.
// - Each byte committed right after its eighth clock, no busy time.
// - Chip select rising ends a write command.
// - Input bits shifted most significant bit first.
// - Read address is two bytes; only the low 11 bits used.
// - After read address, input ignored; eight clocks per output byte.
// - Read data MSB first; chip select rising ends the read.
// - Pause low while clock low freezes the command in place.
// - Pause high while clock low resumes exactly where it stopped.
// - Clock edges during pause advance nothing.
// - Write latch cleared when any write command completes.
// - Write latch cleared at reset.
// - Block bits: none, upper quarter, upper half, whole array.
// - Input sampled on rising clock, output changed on falling clock.
`timescale 1ns/100ps
`default_nettype none
`include "fram_spi_defines.svh"
module serial_fram_access_protect
  import fram_spi_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic write_enable_latch_o,
  output logic block_protect_hi_o,
  output logic block_protect_lo_o,
  output logic status_lock_enable_o
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    addr_inc = (a == `ARRAY_TOP) ? `ADDR_ZERO : ADDR_W'(a + 1'b1);
  endfunction

  function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    logic [ADDR_W+1:0] scaled;
    scaled = {a, 2'b00};
    case (bp)
      2'h0: is_protected = 1'b0;
      2'h1: is_protected = (scaled >= `PROT_QTR_START);
      2'h2: is_protected = (scaled >= `PROT_HALF_START);
      default: is_protected = 1'b1;
    endcase
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic sck_s, cs_n_s, mosi_s, hold_n_s, wp_n_s;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin_meta_reg <= 5'h1E;
      pin_sync_reg <= 5'h1E;
    end else begin
      pin_meta_reg <= {wp_n_i, hold_n_i, mosi_i, cs_n_i, sck_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign sck_s = pin_sync_reg[0];
  assign cs_n_s = pin_sync_reg[1];
  assign mosi_s = pin_sync_reg[2];
  assign hold_n_s = pin_sync_reg[3];
  assign wp_n_s = pin_sync_reg[4];

  // ****************************************
  // Command state
  // ****************************************
  cmd_state_t state_reg, state_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic addr_lo_reg, addr_lo_next;
  logic wr_cmd_reg, wr_cmd_next;
  logic latch_reg, latch_next;
  logic lock_reg, lock_next;
  logic [1:0] bp_reg, bp_next;
  logic held_reg, held_next;
  logic miso_reg, miso_next;
  logic sck_prev_reg, cs_n_prev_reg;
  logic rise_w, fall_w, cs_rise_w;
  logic [7:0] cur_byte;
  logic [7:0] status_byte;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic sr_locked;

  assign rise_w = sck_s & ~sck_prev_reg & ~cs_n_s & ~held_reg;
  assign fall_w = ~sck_s & sck_prev_reg & ~cs_n_s & ~held_reg;
  assign cs_rise_w = cs_n_s & ~cs_n_prev_reg;
  assign cur_byte = {shift_reg[6:0], mosi_s};
  assign sr_locked = lock_reg & ~wp_n_s;
  assign status_byte = {lock_reg, 3'h0, bp_reg, latch_reg, 1'b0};

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    addr_lo_next = addr_lo_reg;
    wr_cmd_next = wr_cmd_reg;
    latch_next = latch_reg;
    lock_next = lock_reg;
    bp_next = bp_reg;
    miso_next = miso_reg;
    mem_we = 1'b0;
    held_next = held_reg;
    // Pause follows the pin only while the serial clock is low; deselect clears it at any clock level
    if (!sck_s) begin
      held_next = ~hold_n_s;
    end
    if (cs_n_s) begin
      // Deselected: any partial byte is simply dropped
      state_next = ST_CMD;
      bit_next = 3'h0;
      addr_lo_next = 1'b0;
      wr_cmd_next = 1'b0;
      held_next = 1'b0;
      if (cs_rise_w && wr_cmd_reg) begin
        latch_next = 1'b0;
      end
    end else if (rise_w) begin
      bit_next = 3'(bit_reg + 3'h1);
      shift_next = cur_byte;
      if (bit_reg == `LAST_BIT) begin
        case (state_reg)
          ST_CMD: begin
            case (cur_byte)
              `SET_WRITE_LATCH_CMD: begin
                latch_next = 1'b1;
                state_next = ST_DONE;
              end
              `CLEAR_WRITE_LATCH_CMD: begin
                latch_next = 1'b0;
                state_next = ST_DONE;
              end
              `STATUS_READ_CMD: begin
                state_next = ST_SR_RD;
              end
              `STATUS_WRITE_CMD: begin
                state_next = ST_SR_WR;
                wr_cmd_next = 1'b1;
              end
              `ARRAY_READ_CMD: begin
                state_next = ST_ADDR;
              end
              `ARRAY_WRITE_CMD: begin
                state_next = ST_ADDR;
                wr_cmd_next = 1'b1;
              end
              default: begin
                state_next = ST_DONE;
              end
            endcase
          end
          ST_ADDR: begin
            if (!addr_lo_reg) begin
              addr_next[ADDR_W-1:8] = cur_byte[ADDR_W-9:0];
              addr_lo_next = 1'b1;
            end else begin
              addr_next[7:0] = cur_byte;
              state_next = wr_cmd_reg ? ST_WR : ST_RD;
            end
          end
          ST_WR: begin
            mem_we = latch_reg & ~is_protected(addr_reg, bp_reg);
            addr_next = addr_inc(addr_reg);
          end
          ST_RD: begin
            addr_next = addr_inc(addr_reg);
          end
          ST_SR_WR: begin
            if (latch_reg && !sr_locked) begin
              lock_next = cur_byte[`SR_LOCK_BIT];
              bp_next = {cur_byte[`SR_BP_HI_BIT], cur_byte[`SR_BP_LO_BIT]};
            end
            state_next = ST_DONE;
          end
          ST_SR_RD: begin
            state_next = ST_DONE;
          end
          default: begin
            state_next = ST_DONE;
          end
        endcase
      end
    end else if (fall_w) begin
      if (state_reg == ST_RD) begin
        miso_next = mem_rdata[3'(`LAST_BIT - bit_reg)];
      end else if (state_reg == ST_SR_RD) begin
        miso_next = status_byte[3'(`LAST_BIT - bit_reg)];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= ST_CMD;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      addr_reg <= `ADDR_ZERO;
      addr_lo_reg <= 1'b0;
      wr_cmd_reg <= 1'b0;
      latch_reg <= `LATCH_RST;
      lock_reg <= `SR_LOCK_RST;
      bp_reg <= `SR_BP_RST;
      held_reg <= 1'b0;
      miso_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      addr_lo_reg <= addr_lo_next;
      wr_cmd_reg <= wr_cmd_next;
      latch_reg <= latch_next;
      lock_reg <= lock_next;
      bp_reg <= bp_next;
      held_reg <= held_next;
      miso_reg <= miso_next;
      sck_prev_reg <= sck_s;
      cs_n_prev_reg <= cs_n_s;
    end
  end

  // ****************************************
  // Array
  // ****************************************
  fram_array #(
    .ADDR_W(ADDR_W),
    .DATA_W(8)
  ) u_array (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .we_i(mem_we),
    .waddr_i(addr_reg),
    .wdata_i(cur_byte),
    .raddr_i(addr_reg),
    .rdata_o(mem_rdata)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign miso_o = miso_reg;
  assign miso_oe_o = ~cs_n_s & ~held_reg & ((state_reg == ST_RD) | (state_reg == ST_SR_RD));
  assign write_enable_latch_o = latch_reg;
  assign block_protect_hi_o = bp_reg[1];
  assign block_protect_lo_o = bp_reg[0];
  assign status_lock_enable_o = lock_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  chk_array_guard: assert property (
    mem_we |-> (latch_reg && rise_w && state_reg == ST_WR && bp_reg != 2'h3
                && !(bp_reg == 2'h2 && addr_reg[ADDR_W-1])
                && !(bp_reg == 2'h1 && addr_reg[ADDR_W-1:ADDR_W-2] == 2'h3)))
    else $error("array written without latch or inside protected block");

  chk_status_lock: assert property (
    (rise_w && state_reg == ST_SR_WR && bit_reg == `LAST_BIT && lock_reg && !wp_n_s)
    |=> (bp_reg == $past(bp_reg) && lock_reg == $past(lock_reg)))
    else $error("status written while locked by protect pin");

  chk_lock_free: assert property (
    (rise_w && state_reg == ST_SR_WR && bit_reg == `LAST_BIT && latch_reg && !lock_reg)
    |=> (bp_reg == $past(cur_byte[3:2]) && lock_reg == $past(cur_byte[7])))
    else $error("status write refused while lock bit clear");

  chk_latch_clear: assert property (
    (cs_rise_w && wr_cmd_reg) |=> !latch_reg)
    else $error("write latch not cleared after write command");

  chk_addr_wrap: assert property (
    (rise_w && bit_reg == `LAST_BIT && (state_reg == ST_WR || state_reg == ST_RD)
     && addr_reg == `ARRAY_TOP) |=> (addr_reg == `ADDR_ZERO))
    else $error("address did not wrap to zero");

  chk_hold_freeze: assert property (
    (held_reg && !cs_n_s) |=> (bit_reg == $past(bit_reg) && addr_reg == $past(addr_reg)
                               && state_reg == $past(state_reg)))
    else $error("command advanced while paused");

  chk_addr_step: assert property (
    mem_we |=> (addr_reg == addr_inc($past(addr_reg))))
    else $error("address not advanced after committed byte");

  chk_out_edge: assert property (
    $changed(miso_reg) |-> $past(fall_w))
    else $error("output changed away from a falling clock edge");

  chk_deselect_idle: assert property (
    cs_n_s |-> (!mem_we ##1 (bit_reg == 3'h0 && state_reg == ST_CMD)))
    else $error("activity while deselected");

  cov_array_write: cover property (mem_we);
  cov_status_write: cover property (rise_w && state_reg == ST_SR_WR && bit_reg == `LAST_BIT);
  cov_read_wrap: cover property (rise_w && state_reg == ST_RD && addr_reg == `ARRAY_TOP
                                 && bit_reg == `LAST_BIT);
  cov_pause: cover property (held_reg && !cs_n_s ##1 !held_reg && !cs_n_s);

endmodule
`default_nettype wire

// [dv/spi_host_model.sv]
// SPI bus master model driving the serial memory pins in mode 0
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic clock_i,
  input wire logic miso_i,
  input wire logic miso_oe_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  output logic hold_n_o
);
  logic oe_in_pause;
  logic oe_at_bit;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    hold_n_o = 1'b1;
    oe_in_pause = 1'b0;
    oe_at_bit = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic open_frame();
    cs_n_o <= 1'b0;
    wait_clk(6);
  endtask
  // Released data line shows a changed level, not the last bit
  task automatic close_frame();
    sck_o <= 1'b0;
    wait_clk(6);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    wait_clk(6);
  endtask
  // Shifts nbits of tx MSB first; pauses with clock low before bit hold_at
  task automatic xfer(input logic [7:0] tx, input int nbits, input int hold_at,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      mosi_o <= tx[7-i];
      sck_o <= 1'b0;
      wait_clk(6);
      if (i == hold_at) begin
        hold_n_o <= 1'b0;
        wait_clk(5);
        oe_in_pause = miso_oe_i;
        repeat (3) begin
          sck_o <= 1'b1;
          mosi_o <= ~mosi_o;
          wait_clk(4);
          sck_o <= 1'b0;
          wait_clk(4);
        end
        hold_n_o <= 1'b1;
        mosi_o <= tx[7-i];
        wait_clk(6);
      end
      rx = {rx[6:0], miso_i};
      oe_at_bit = miso_oe_i;
      sck_o <= 1'b1;
      wait_clk(6);
    end
  endtask
endmodule
`default_nettype wire

// [dv/test_serial_fram_access_protect.sv]
// Self-checking bench for the serial memory slave
`timescale 1ns/100ps
`default_nettype none
`include "fram_spi_defines.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_serial_fram_access_protect;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic wp_n_i = 1'b1;
  wire logic sck, cs_n, mosi, hold_n, miso, miso_oe;
  wire logic write_enable_latch, bph, bpl, lck;
  int mem [2048];
  bit m_latch, m_lock;
  bit [1:0] m_bp;
  int failures = 0;
  int check_count = 0;
  int seed = 99;
  logic [7:0] rx;
  logic wps [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0] svs [7] = '{8'h80, 8'h8C, 8'h00, 8'h0A, 8'h88, 8'h00, 8'h00};
  always #50 clock_i = ~clock_i;
  serial_fram_access_protect i_serial_fram_access_protect (.clock_i(clock_i),
    .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .hold_n_i(hold_n),
    .wp_n_i(wp_n_i), .miso_o(miso), .miso_oe_o(miso_oe), .write_enable_latch_o(write_enable_latch),
    .block_protect_hi_o(bph), .block_protect_lo_o(bpl), .status_lock_enable_o(lck));
  spi_host_model i_spi_host_model (.clock_i(clock_i), .miso_i(miso), .miso_oe_i(miso_oe),
    .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .hold_n_o(hold_n));
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic bit blocked(int a);
    return m_bp == 3 || (m_bp == 2 && a >= 'h400) || (m_bp == 1 && a >= 'h600);
  endfunction
  task automatic pins();
    `CHK({lck, bph, bpl, write_enable_latch}, {m_lock, m_bp, m_latch})
  endtask
  task automatic cmd(input logic [7:0] op);
    i_spi_host_model.open_frame();
    i_spi_host_model.xfer(op, 8, 99, rx);
    i_spi_host_model.close_frame();
    if (op == `SET_WRITE_LATCH_CMD) m_latch = 1;
    if (op == `CLEAR_WRITE_LATCH_CMD) m_latch = 0;
    pins();
  endtask
  // Last byte carries nlast bits and may pause before bit hold_at
  task automatic mem_op(input bit wr, input logic [15:0] a16, input int n, input int nlast,
                        input int hold_at);
    int a;
    logic [7:0] d;
    a = a16[10:0];
    i_spi_host_model.open_frame();
    i_spi_host_model.xfer(wr ? `ARRAY_WRITE_CMD : `ARRAY_READ_CMD, 8, 99, rx);
    i_spi_host_model.xfer(a16[15:8], 8, 99, rx);
    i_spi_host_model.xfer(a16[7:0], 8, 99, rx);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      i_spi_host_model.xfer(d, (k == n-1) ? nlast : 8, (k == n-1) ? hold_at : 99, rx);
      if (k == n-1 && hold_at < 8) `CHK(i_spi_host_model.oe_in_pause, 1'b0)
      `CHK(i_spi_host_model.oe_at_bit, !wr)
      if (!wr && mem[a] >= 0) `CHK(rx, mem[a][7:0])
      if (wr && m_latch && !blocked(a) && (k < n-1 || nlast == 8)) mem[a] = d;
      a = (a + 1) % 2048;
    end
    i_spi_host_model.close_frame();
    if (wr) m_latch = 0;
    pins();
  endtask
  task automatic status_op(input bit wr, input logic [7:0] v);
    i_spi_host_model.open_frame();
    i_spi_host_model.xfer(wr ? `STATUS_WRITE_CMD : `STATUS_READ_CMD, 8, 99, rx);
    i_spi_host_model.xfer(v, 8, 99, rx);
    i_spi_host_model.close_frame();
    if (!wr) `CHK(rx, {m_lock, 3'h0, m_bp, m_latch, 1'b0})
    `CHK(i_spi_host_model.oe_at_bit, !wr)
    if (wr && m_latch && !(m_lock && !wp_n_i)) {m_lock, m_bp} = {v[7], v[3:2]};
    if (wr) m_latch = 0;
    pins();
  endtask
  initial begin
    repeat (90000) @(posedge clock_i);
    failures++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = -1;
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    pins();
    status_op(0, 8'h00);
    cmd(`SET_WRITE_LATCH_CMD);
    mem_op(1, 16'hF7FE, 4, 8, 99);
    mem_op(0, 16'hFFFE, 4, 8, 99);
    $display("test wrap done");
    for (int v = 0; v < 3; v++) begin
      if (v > 0) cmd(`SET_WRITE_LATCH_CMD);
      if (v > 1) cmd(`CLEAR_WRITE_LATCH_CMD);
      mem_op(1, 16'h0010, 2, 8, 99);
      mem_op(0, 16'h0010, 2, 8, 99);
    end
    $display("test latch done");
    for (int b = 0; b < 4; b++) begin
      cmd(`SET_WRITE_LATCH_CMD);
      status_op(1, {4'h0, 2'(b), 2'h0});
      for (int a = 'h3FF; a < 'h600; a += 'h200) begin
        cmd(`SET_WRITE_LATCH_CMD);
        mem_op(1, 16'(a), 2, 8, 99);
        mem_op(0, 16'(a), 2, 8, 99);
      end
    end
    $display("test block done");
    for (int i = 0; i < 7; i++) begin
      wp_n_i <= wps[i];
      cmd(`SET_WRITE_LATCH_CMD);
      status_op(1, svs[i]);
      status_op(0, 8'h00);
      if (i == 4) cmd(`SET_WRITE_LATCH_CMD);
      if (i == 4) mem_op(1, 16'h0020, 2, 8, 99);
      if (i == 4) mem_op(0, 16'h0020, 2, 8, 99);
    end
    $display("test lock done");
    cmd(`SET_WRITE_LATCH_CMD);
    mem_op(1, 16'h0100, 3, 8, 99);
    cmd(`SET_WRITE_LATCH_CMD);
    mem_op(1, 16'h0100, 3, 5, 99);
    mem_op(0, 16'h0100, 3, 8, 99);
    $display("test partial done");
    cmd(`SET_WRITE_LATCH_CMD);
    mem_op(1, 16'h0200, 2, 8, 3);
    mem_op(0, 16'h0200, 2, 8, 4);
    $display("test pause done");
    complete_run();
  end
endmodule
`default_nettype wire
